// file: hw/mpg_port0_gpio.sv
// port 0 pin logic with alternate functions, plus port 1 reset/spi setup
//
// Operation
// - alternate select outranks direction bit, except uart receive pin
// - alternate pins follow their function; receive pin obeys direction
// - bit0 timer out, 1/2 uart, 3/4 interrupts, 5/6 timers, 7 pwm
// - interrupt pins reach interrupt logic only with their select set
// - timer count pins sampled once every four clocks
// - cleared select makes the pin plain gpio using its direction bit
// - direction bit 0 drives the pin, 1 makes it an input
// - every port 0 pin is an input throughout reset
// - during reset port 1 drives clock and data out, data in input
// - port 0 reset configuration holds until software writes the registers; port 1 follows its route and gpio inputs from the first clock
// - data and direction reset to ones, drive and select to zeros
// - drive bit gives odd pins high source, even pins high sink
// - the four registers sit at their special-function addresses
// - port 1 spi roles only while route control equals 01
`timescale 1ns/1ns
`include "mpg_defines.svh"
module mpg_port0_gpio
    import mpg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic [7:0] port0_pins_in,
    output logic      [7:0] port0_pins_out,
    output logic      [7:0] port0_pins_oe_n,
    output logic      [7:0] port0_high_source,
    output logic      [7:0] port0_high_sink,
    input  wire logic       general_timer_output,
    input  wire logic       uart_rxd_out,
    input  wire logic       uart_txd,
    input  wire logic       pwm_out,
    output logic            uart_rxd_in,
    output logic            external_interrupt_zero_n,
    output logic            external_interrupt_one_n,
    output logic            timer_zero_input,
    output logic            timer_one_input,
    input  wire logic [1:0] spi_route_ctrl,
    input  wire logic       spi_clock_out,
    input  wire logic       spi_data_out,
    output logic            spi_data_in,
    input  wire logic [3:0] port1_gpio_out,
    input  wire logic [3:0] port1_gpio_dir,
    input  wire logic [3:0] port1_pins_in,
    output logic      [3:0] port1_pins_out,
    output logic      [3:0] port1_pins_oe_n
);
    mpg_port_if #(.W(8)) pif ();

    mpg_byte_t  pin_level;
    mpg_byte_t  alt_out;
    mpg_byte_t  alt_oe_n;
    mpg_byte_t  next_pins_out;
    mpg_byte_t  next_oe_n;
    mpg_byte_t  next_source;
    mpg_byte_t  next_sink;
    mpg_byte_t  next_rdata;
    logic       next_rxd_in;
    logic       next_external_interrupt_zero;
    logic       next_external_interrupt_one;
    logic [3:0] next_p1_out;
    logic [3:0] next_p1_oe_n;
    logic       spi_routed;

    mpg_sfr_regs u_regs (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .sfr_addr  (sfr_addr),
        .sfr_wr    (sfr_wr),
        .sfr_wdata (sfr_wdata),
        .rif       (pif.regs)
    );

    mpg_timer_sampler u_sampler (
        .clk     (clk),
        .sys_rst (sys_rst),
        .sif     (pif.sampler)
    );

    // raw pins go to the sampler; it alone decides when they count
    assign pif.timer_pins = {port0_pins_in[`MPG_BIT_T1],
                             port0_pins_in[`MPG_BIT_T0]};
    assign timer_zero_input = pif.timer_level[0];
    assign timer_one_input  = pif.timer_level[1];
    assign spi_routed = (spi_route_ctrl == `MPG_SPI_ROUTE_P1);

    // port 0 pin direction and output value
    always_comb
    begin
        alt_out = {pwm_out, 4'h0, uart_txd, uart_rxd_out,
                   general_timer_output};
        // fixed-function pins: outputs drive, inputs float
        alt_oe_n = ~`MPG_ALT_OUT_MASK;
        alt_oe_n[`MPG_BIT_RXD] = pif.dir[`MPG_BIT_RXD];
        // select wins over direction per bit
        next_oe_n = (pif.alt & alt_oe_n) |
                    (~pif.alt & pif.dir);
        next_pins_out = (pif.alt & alt_out) |
                        (~pif.alt & pif.data);
        next_source = pif.drv & `MPG_ODD_MASK;
        next_sink   = pif.drv & `MPG_EVEN_MASK;
    end

    // inputs handed to uart and interrupt logic; idle high when deselected
    always_comb
    begin
        next_rxd_in = pif.alt[`MPG_BIT_RXD] ?
                      port0_pins_in[`MPG_BIT_RXD] : 1'b1;
        next_external_interrupt_zero = pif.alt[`MPG_BIT_INT0] ?
                      port0_pins_in[`MPG_BIT_INT0] : 1'b1;
        next_external_interrupt_one = pif.alt[`MPG_BIT_INT1] ?
                      port0_pins_in[`MPG_BIT_INT1] : 1'b1;
    end

    // port 1: spi master roles or plain gpio; data in pin never drives
    always_comb
    begin
        if (spi_routed)
        begin
            next_p1_out  = {port1_gpio_out[3], 1'b0,
                            spi_data_out, spi_clock_out};
            next_p1_oe_n = {port1_gpio_dir[3], 1'b1, 1'b0, 1'b0};
        end
        else
        begin
            next_p1_out  = port1_gpio_out;
            next_p1_oe_n = port1_gpio_dir | `MPG_P1_RST_OE_N;
        end
    end

    // registered read; unmapped addresses return zero
    always_comb
    begin
        next_rdata = sfr_rdata;
        if (sfr_rd)
        begin
            case (sfr_addr)
                `MPG_ADDR_DATA: next_rdata = pin_level;
                `MPG_ADDR_DRV:  next_rdata = pif.drv;
                `MPG_ADDR_DIR:  next_rdata = pif.dir;
                `MPG_ADDR_ALT:  next_rdata = pif.alt;
                default:        next_rdata = 8'h00;
            endcase
        end
    end

    // enables reset asynchronously so port 0 pins float even with no clock
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            port0_pins_oe_n   <= 8'hFF;
            port0_pins_out    <= `MPG_RST_DATA;
            port0_high_source <= 8'h00;
            port0_high_sink   <= 8'h00;
            port1_pins_oe_n   <= `MPG_P1_RST_OE_N;
            port1_pins_out    <= 4'h0;
            pin_level         <= 8'hFF;
            sfr_rdata         <= 8'h00;
            uart_rxd_in       <= 1'b1;
            external_interrupt_zero_n <= 1'b1;
            external_interrupt_one_n  <= 1'b1;
            spi_data_in       <= 1'b0;
        end
        else
        begin
            port0_pins_oe_n   <= next_oe_n;
            port0_pins_out    <= next_pins_out;
            port0_high_source <= next_source;
            port0_high_sink   <= next_sink;
            port1_pins_oe_n   <= next_p1_oe_n;
            port1_pins_out    <= next_p1_out;
            pin_level         <= port0_pins_in;
            sfr_rdata         <= next_rdata;
            uart_rxd_in       <= next_rxd_in;
            external_interrupt_zero_n <= next_external_interrupt_zero;
            external_interrupt_one_n  <= next_external_interrupt_one;
            spi_data_in       <= port1_pins_in[`MPG_P1_MISO];
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    property p_reset_inputs;
        $fell(sys_rst) |-> port0_pins_oe_n == 8'hFF &&
            port1_pins_oe_n == `MPG_P1_RST_OE_N;
    endproperty
    a_reset_inputs: assert property (p_reset_inputs)
        else $error("pins not in reset configuration");

    property p_alt_input_wins;
        pif.alt[`MPG_BIT_INT0] && pif.alt[`MPG_BIT_T0] |=>
            port0_pins_oe_n[`MPG_BIT_INT0] &&
            port0_pins_oe_n[`MPG_BIT_T0];
    endproperty
    a_alt_input_wins: assert property (p_alt_input_wins)
        else $error("selected input pin is driven");

    property p_rxd_dir;
        pif.alt[`MPG_BIT_RXD] |=>
            port0_pins_oe_n[`MPG_BIT_RXD] ==
            $past(pif.dir[`MPG_BIT_RXD]);
    endproperty
    a_rxd_dir: assert property (p_rxd_dir)
        else $error("receive pin ignores its direction bit");

    property p_pwm_route;
        pif.alt[`MPG_BIT_PWM] |=> !port0_pins_oe_n[`MPG_BIT_PWM] &&
            port0_pins_out[`MPG_BIT_PWM] == $past(pwm_out);
    endproperty
    a_pwm_route: assert property (p_pwm_route)
        else $error("pulse-width output not routed");

    property p_txd_route;
        pif.alt[`MPG_BIT_TXD] |=> !port0_pins_oe_n[`MPG_BIT_TXD] &&
            port0_pins_out[`MPG_BIT_TXD] == $past(uart_txd);
    endproperty
    a_txd_route: assert property (p_txd_route)
        else $error("uart transmit not routed");

    property p_general_timer_output_route;
        pif.alt[`MPG_BIT_GENERAL_TIMER_OUTPUT] |=> !port0_pins_oe_n[`MPG_BIT_GENERAL_TIMER_OUTPUT] &&
            port0_pins_out[`MPG_BIT_GENERAL_TIMER_OUTPUT] == $past(general_timer_output);
    endproperty
    a_general_timer_output_route: assert property (p_general_timer_output_route)
        else $error("general timer output not routed");

    // a deselected timer pin reads zero from the next sample on
    property p_timer_gate;
        !pif.alt[`MPG_BIT_T0] && pif.strobe |=> !timer_zero_input;
    endproperty
    a_timer_gate: assert property (p_timer_gate)
        else $error("timer input passed while not selected");

    property p_int_gate;
        !pif.alt[`MPG_BIT_INT0] |=> external_interrupt_zero_n;
    endproperty
    a_int_gate: assert property (p_int_gate)
        else $error("interrupt passed while not selected");

    property p_int_pass;
        pif.alt[`MPG_BIT_INT1] |=>
            external_interrupt_one_n == $past(port0_pins_in[4]);
    endproperty
    a_int_pass: assert property (p_int_pass)
        else $error("selected interrupt pin not passed");

    property p_gpio_dir;
        1'b1 |=> (port0_pins_oe_n & ~$past(pif.alt)) ==
                 ($past(pif.dir) & ~$past(pif.alt));
    endproperty
    a_gpio_dir: assert property (p_gpio_dir)
        else $error("gpio pin direction wrong");

    property p_gpio_data;
        1'b1 |=> (port0_pins_out & ~$past(pif.alt)) ==
                 ($past(pif.data) & ~$past(pif.alt));
    endproperty
    a_gpio_data: assert property (p_gpio_data)
        else $error("gpio output latch not driven");

    property p_drive;
        1'b1 |=> port0_high_source == ($past(pif.drv) & 8'hAA) &&
                 port0_high_sink == ($past(pif.drv) & 8'h55);
    endproperty
    a_drive: assert property (p_drive)
        else $error("drive strength mapping wrong");

    property p_p1_gpio;
        !spi_routed |=> port1_pins_oe_n ==
            ($past(port1_gpio_dir) | 4'h4);
    endproperty
    a_p1_gpio: assert property (p_p1_gpio)
        else $error("port 1 not gpio with routing off");

    property p_p1_spi;
        spi_routed |=> port1_pins_oe_n[2:0] == 3'h4 &&
            port1_pins_out[0] == $past(spi_clock_out);
    endproperty
    a_p1_spi: assert property (p_p1_spi)
        else $error("port 1 not in spi master roles");

    property p_read_pins;
        sfr_rd && sfr_addr == `MPG_ADDR_DATA |=>
            sfr_rdata == $past(port0_pins_in, 2);
    endproperty
    a_read_pins: assert property (p_read_pins)
        else $error("data read does not show pin levels");

    property p_timer_hold;
        !pif.strobe |=> $stable(timer_zero_input);
    endproperty
    a_timer_hold: assert property (p_timer_hold)
        else $error("timer input changed between samples");
endmodule : mpg_port0_gpio

// file: hw/mpg_defines.svh
// register offsets, reset values, bit positions and counts for port 0
`ifndef MPG_DEFINES_SVH
`define MPG_DEFINES_SVH
`define MPG_ADDR_DATA     8'h80
`define MPG_ADDR_DRV      8'h93
`define MPG_ADDR_DIR      8'h94
`define MPG_ADDR_ALT      8'h95
`define MPG_RST_DATA      8'hFF
`define MPG_RST_DRV       8'h00
`define MPG_RST_DIR       8'hFF
`define MPG_RST_ALT       8'h00
`define MPG_BIT_GENERAL_TIMER_OUTPUT    0
`define MPG_BIT_RXD       1
`define MPG_BIT_TXD       2
`define MPG_BIT_INT0      3
`define MPG_BIT_INT1      4
`define MPG_BIT_T0        5
`define MPG_BIT_T1        6
`define MPG_BIT_PWM       7
`define MPG_ODD_MASK      8'hAA
`define MPG_EVEN_MASK     8'h55
`define MPG_ALT_OUT_MASK  8'h85
`define MPG_SPI_ROUTE_P1  2'h1
`define MPG_P1_RST_OE_N   4'h4
`define MPG_P1_MISO       2
`define MPG_SAMPLE_PERIOD 4
`endif

// file: hw/mpg_pkg.sv
// types shared by the port 0 block
package mpg_pkg;
    typedef logic [7:0] mpg_byte_t;
    typedef enum logic [3:0] {
        MPG_PH0 = 4'h1,
        MPG_PH1 = 4'h2,
        MPG_PH2 = 4'h4,
        MPG_PH3 = 4'h8
    } mpg_phase_t;
endpackage : mpg_pkg

// file: hw/mpg_port_if.sv
// register contents and timer sampling between port 0 modules
`timescale 1ns/1ns
interface mpg_port_if #(parameter int W = 8);
    logic [W-1:0] data;
    logic [W-1:0] drv;
    logic [W-1:0] dir;
    logic [W-1:0] alt;
    logic [1:0]   timer_pins;
    logic [1:0]   timer_level;
    logic         strobe;
    modport regs    (output data, drv, dir, alt);
    modport sampler (input alt, timer_pins,
                     output timer_level, strobe);
    modport core    (input data, drv, dir, alt, timer_level, strobe,
                     output timer_pins);
endinterface : mpg_port_if

// file: hw/mpg_sfr_regs.sv
// port 0 control and data registers in the special-function space
`timescale 1ns/1ns
`include "mpg_defines.svh"
module mpg_sfr_regs
    import mpg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    mpg_port_if.regs        rif
);
    mpg_byte_t next_data;
    mpg_byte_t next_drv;
    mpg_byte_t next_dir;
    mpg_byte_t next_alt;

    always_comb
    begin
        next_data = rif.data;
        next_drv  = rif.drv;
        next_dir  = rif.dir;
        next_alt  = rif.alt;
        if (sfr_wr)
        begin
            case (sfr_addr)
                `MPG_ADDR_DATA: next_data = sfr_wdata;
                `MPG_ADDR_DRV:  next_drv  = sfr_wdata;
                `MPG_ADDR_DIR:  next_dir  = sfr_wdata;
                `MPG_ADDR_ALT:  next_alt  = sfr_wdata;
                default:        next_data = rif.data;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rif.data <= `MPG_RST_DATA;
            rif.drv  <= `MPG_RST_DRV;
            rif.dir  <= `MPG_RST_DIR;
            rif.alt  <= `MPG_RST_ALT;
        end
        else
        begin
            rif.data <= next_data;
            rif.drv  <= next_drv;
            rif.dir  <= next_dir;
            rif.alt  <= next_alt;
        end
    end

    property p_reset_values;
        @(posedge clk) $fell(sys_rst) |->
            rif.data == `MPG_RST_DATA && rif.dir == `MPG_RST_DIR &&
            rif.drv == `MPG_RST_DRV && rif.alt == `MPG_RST_ALT;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("port 0 register reset value wrong");

    property p_dir_write;
        @(posedge clk) disable iff (sys_rst)
        sfr_wr && sfr_addr == `MPG_ADDR_DIR |=>
            rif.dir == $past(sfr_wdata);
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("direction register write lost");

    property p_config_held;
        @(posedge clk) disable iff (sys_rst)
        !sfr_wr |=> $stable(rif.dir) && $stable(rif.alt);
    endproperty
    a_config_held: assert property (p_config_held)
        else $error("pin configuration changed without a write");
endmodule : mpg_sfr_regs

// file: hw/mpg_timer_sampler.sv
// samples the timer count pins once every four clocks
`timescale 1ns/1ns
`include "mpg_defines.svh"
module mpg_timer_sampler
    import mpg_pkg::*;
(
    input  wire logic clk,
    input  wire logic sys_rst,
    mpg_port_if.sampler sif
);
    mpg_phase_t phase;
    mpg_phase_t next_phase;
    logic [1:0] next_level;
    logic [1:0] sel;

    assign sel = {sif.alt[`MPG_BIT_T1], sif.alt[`MPG_BIT_T0]};
    assign sif.strobe = (phase == MPG_PH3);

    always_comb
    begin
        next_level = sif.timer_level;
        case (phase)
            MPG_PH0: next_phase = MPG_PH1;
            MPG_PH1: next_phase = MPG_PH2;
            MPG_PH2: next_phase = MPG_PH3;
            MPG_PH3:
            begin
                next_phase = MPG_PH0;
                next_level = sif.timer_pins & sel;
            end
            default: next_phase = MPG_PH0;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            phase           <= MPG_PH0;
            sif.timer_level <= 2'h0;
        end
        else
        begin
            phase           <= next_phase;
            sif.timer_level <= next_level;
        end
    end

    property p_sample_spacing;
        @(posedge clk) disable iff (sys_rst)
        sif.strobe |=> !sif.strobe [*3] ##1 sif.strobe;
    endproperty
    a_sample_spacing: assert property (p_sample_spacing)
        else $error("timer pins not sampled every four clocks");
endmodule : mpg_timer_sampler

// file: verif/mpg_board_model.sv
// board side of port 0 and port 1: resolves driven and external levels
`timescale 1ns/1ns
module mpg_board_model
(
    input  wire logic [7:0] p0_out,
    input  wire logic [7:0] p0_oe_n,
    input  wire logic [7:0] p0_ext,
    output logic      [7:0] p0_in,
    input  wire logic [3:0] p1_out,
    input  wire logic [3:0] p1_oe_n,
    input  wire logic [3:0] p1_ext,
    output logic      [3:0] p1_in
);
    // a driven pin shows the device level, an undriven one the board source
    assign p0_in = (p0_out & ~p0_oe_n) | (p0_ext & p0_oe_n);
    assign p1_in = (p1_out & ~p1_oe_n) | (p1_ext & p1_oe_n);
endmodule : mpg_board_model

// file: verif/mpg_port0_gpio_tb.sv
// self-checking bench for the port 0 pin block
`timescale 1ns/1ns
`include "mpg_defines.svh"
module mpg_port0_gpio_tb;
    import mpg_pkg::*;
    logic        clk, sys_rst, sfr_wr, sfr_rd;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, q;
    logic [7:0]  p0_in, p0_out, p0_oe_n, p0_ext, hi_src, hi_snk;
    logic [7:0]  drv, dir, dat, alt, eoe, bad, pe;
    logic        gt_o, rx_o, tx_o, pwm_o, rx_i, external_interrupt_zero, external_interrupt_one, t0_i, t1_i;
    logic        sck, mosi, miso, pv0, pv1;
    logic [1:0]  route;
    logic [3:0]  p1_gout, p1_gdir, p1_in, p1_out, p1_oe_n, p1_ext, e1;
    logic [7:0]  alts [6] = '{8'h00, 8'hFF, 8'h18, 8'h7E, 8'h02, 8'h85};
    logic [15:0] lf;
    int          fails, num_checks, first, nchg;

    mpg_port0_gpio u_mpg_port0_gpio (.clk(clk), .sys_rst(sys_rst),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .port0_pins_in(p0_in), .port0_pins_out(p0_out),
        .port0_pins_oe_n(p0_oe_n), .port0_high_source(hi_src),
        .port0_high_sink(hi_snk), .general_timer_output(gt_o),
        .uart_rxd_out(rx_o), .uart_txd(tx_o), .pwm_out(pwm_o),
        .uart_rxd_in(rx_i), .external_interrupt_zero_n(external_interrupt_zero),
        .external_interrupt_one_n(external_interrupt_one), .timer_zero_input(t0_i),
        .timer_one_input(t1_i), .spi_route_ctrl(route),
        .spi_clock_out(sck), .spi_data_out(mosi), .spi_data_in(miso),
        .port1_gpio_out(p1_gout), .port1_gpio_dir(p1_gdir),
        .port1_pins_in(p1_in), .port1_pins_out(p1_out),
        .port1_pins_oe_n(p1_oe_n));

    mpg_board_model u_mpg_board_model (.p0_out(p0_out), .p0_oe_n(p0_oe_n),
        .p0_ext(p0_ext), .p0_in(p0_in), .p1_out(p1_out),
        .p1_oe_n(p1_oe_n), .p1_ext(p1_ext), .p1_in(p1_in));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    // pins 3..6 forced input, 0/2/7 forced output, pin 1 keeps its dir bit
    function automatic logic [7:0] exp_oe(input logic [7:0] a,
                                          input logic [7:0] d);
        exp_oe = (d & ~a) | (a & 8'h78) | (a & d & 8'h02);
    endfunction : exp_oe

    function automatic logic [7:0] exp_out(input logic [7:0] a,
                                           input logic [7:0] l);
        exp_out = (l & ~a) | (a & {pwm_o, 4'h0, tx_o, rx_o, gt_o});
    endfunction : exp_out

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic conclude();
        if (fails == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    // one idle edge first, so back-to-back calls never reassign a strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge clk);
        sfr_wr    <= 1'b0;
    endtask : wr

    // read data holds until the next read, so one spare edge is safe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge clk);
        sfr_rd   <= 1'b0;
        @(posedge clk);
        #1;
        d = sfr_rdata;
    endtask : rd

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        fails++;
        conclude();
    end

    initial
    begin
        sys_rst = 1'b1; sfr_wr = 1'b0; sfr_rd = 1'b0; sfr_addr = 8'h00;
        sfr_wdata = 8'h00; gt_o = 1'b0; rx_o = 1'b0; tx_o = 1'b0;
        pwm_o = 1'b0; route = 2'h1; sck = 1'b0; mosi = 1'b0;
        p1_gout = 4'h0; p1_gdir = 4'hF; p1_ext = 4'hA; p0_ext = 8'h5A;
        lf = 16'd41312; fails = 0; num_checks = 0;
        repeat (4) @(posedge clk);
        #1;
        chk(p0_oe_n, 8'hFF);
        chk({4'h0, p1_oe_n}, {4'h0, `MPG_P1_RST_OE_N});
        @(posedge clk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk(p0_oe_n, 8'hFF);
        chk(hi_src | hi_snk, 8'h00);
        chk({6'h00, external_interrupt_zero, t0_i}, 8'h02);
        rd(`MPG_ADDR_DRV, q); chk(q, `MPG_RST_DRV);
        rd(`MPG_ADDR_DIR, q); chk(q, `MPG_RST_DIR);
        rd(`MPG_ADDR_ALT, q); chk(q, `MPG_RST_ALT);
        rd(`MPG_ADDR_DATA, q); chk(q, p0_ext);
        wr(8'h96, 8'hFF);
        rd(8'h96, q); chk(q, 8'h00);
        rd(`MPG_ADDR_ALT, q); chk(q, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            lf = lfsr_next(lf); drv = lf[7:0]; dir = lf[15:8];
            lf = lfsr_next(lf); dat = lf[7:0]; alt = alts[i];
            @(posedge clk);
            {pwm_o, tx_o, rx_o, gt_o} <= lf[11:8];
            p0_ext <= (i == 2) ? 8'h00 : lf[15:8];
            wr(`MPG_ADDR_DRV, drv); wr(`MPG_ADDR_DIR, dir);
            wr(`MPG_ADDR_DATA, dat); wr(`MPG_ADDR_ALT, alt);
            settle();
            eoe = exp_oe(alt, dir);
            chk(hi_src, drv & `MPG_ODD_MASK);
            chk(hi_snk, drv & `MPG_EVEN_MASK);
            chk(p0_oe_n, eoe);
            chk(p0_out & ~eoe,
                exp_out(alt, dat) & ~eoe);
            chk({7'h00, external_interrupt_zero}, {7'h00, ~alt[3] | p0_ext[3]});
            chk({7'h00, external_interrupt_one}, {7'h00, ~alt[4] | p0_ext[4]});
            if (alt[1] && dir[1])
                chk({7'h00, rx_i}, {7'h00, p0_ext[1]});
            rd(`MPG_ADDR_DIR, q); chk(q, dir);
            rd(`MPG_ADDR_ALT, q); chk(q, alt);
        end
        wr(`MPG_ADDR_ALT, 8'h60);
        settle();
        pv0 = t0_i; pv1 = t1_i; first = -1; nchg = 0; bad = 8'h00;
        for (int i = 0; i < 40; i++)
        begin
            @(posedge clk);
            pe = p0_ext;
            lf = lfsr_next(lf);
            p0_ext <= lf[7:0];
            #1;
            if (t0_i !== pv0 || t1_i !== pv1)
            begin
                chk({6'h00, t1_i, t0_i}, {6'h00, pe[6:5]});
                if (first < 0)
                    first = i;
                else if ((i - first) % `MPG_SAMPLE_PERIOD != 0)
                    bad++;
                nchg++;
            end
            pv0 = t0_i; pv1 = t1_i;
        end
        chk(bad, 8'h00);
        chk({7'h00, nchg > 1}, 8'h01);
        for (int r = 0; r < 4; r++)
        begin
            lf = lfsr_next(lf);
            @(posedge clk);
            route <= r[1:0]; p1_gout <= lf[3:0]; p1_gdir <= lf[7:4];
            sck <= lf[8]; mosi <= lf[9]; p1_ext <= lf[15:12];
            settle();
            e1 = (r == 1) ? {lf[7], 3'h4} : (lf[7:4] | 4'h4);
            chk({4'h0, p1_oe_n}, {4'h0, e1});
            if (r == 1)
            begin
                chk({4'h0, p1_out & ~e1},
                    {4'h0, {lf[3], 1'b0, lf[9:8]} & ~e1});
                chk({7'h00, miso}, {7'h00, lf[14]});
            end
            else
                chk({4'h0, p1_out & ~e1}, {4'h0, lf[3:0] & ~e1});
        end
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(p0_oe_n, 8'hFF);
        @(posedge clk);
        sys_rst <= 1'b0;
        rd(`MPG_ADDR_ALT, q); chk(q, `MPG_RST_ALT);
        rd(`MPG_ADDR_DIR, q); chk(q, `MPG_RST_DIR);
        conclude();
    end
endmodule : mpg_port0_gpio_tb
